// file: pkg/cssc_defs.svh
`ifndef CSSC_DEFS_SVH
`define CSSC_DEFS_SVH

// Register byte offsets
`define CSSC_ADDR_WORD_A     8'h00
`define CSSC_ADDR_WORD_B     8'h04
`define CSSC_ADDR_WORD_C     8'h08
`define CSSC_ADDR_CAP_PRI    8'h0c
`define CSSC_ADDR_CAP_SEC    8'h10
`define CSSC_ADDR_FILL       8'h14
`define CSSC_ADDR_FAST_CAP   8'h18
`define CSSC_ADDR_CEILING    8'h1c
`define CSSC_ADDR_FLOOR      8'h20
`define CSSC_ADDR_STATUS     8'h24

// Reset values
`define CSSC_RST_WORD_A      16'h0000
`define CSSC_RST_WORD_B      16'h0000
`define CSSC_RST_WORD_C      16'h0000
`define CSSC_RST_CAP_PRI     16'h0000
`define CSSC_RST_CAP_SEC     16'h0000
`define CSSC_RST_FILL        16'h0000
`define CSSC_RST_FAST_CAP    16'h0000
`define CSSC_RST_CEILING     16'h0000
`define CSSC_RST_FLOOR       16'h0000

// Field positions
`define CSSC_A_VREF_LO       0
`define CSSC_A_VREF_HI       1
`define CSSC_A_TURBO_DIS     2
`define CSSC_A_WD_DIS        7
`define CSSC_B_PLATFORM_POWER_MONITOR_EN       3
`define CSSC_B_DISCHARGE_MONITOR_OUT_EN       4
`define CSSC_B_INPUT_CURRENT_MONITOR_OUT_EN       5
`define CSSC_C_TWO_LEVEL     12
`define CSSC_C_TRICKLE_LO    14
`define CSSC_C_TRICKLE_HI    15

// Timing
`define CSSC_CLK_PERIOD_NS   10
`define CSSC_TICK_NS         1000000
`define CSSC_TICK_CYCLES     (`CSSC_TICK_NS / `CSSC_CLK_PERIOD_NS)
`define CSSC_TURBO_EXIT_MS   20
`define CSSC_WD_S            175
`define CSSC_WD_TICKS        (`CSSC_WD_S * 1000)
`define CSSC_T1_CYCLES       100000
`define CSSC_T2_CYCLES       100000

`endif

// file: pkg/cssc_pkg.sv
package cssc_pkg;

    typedef enum logic [1:0] {
        CSSC_LIM_IDLE,
        CSSC_LIM_SECONDARY,
        CSSC_LIM_PRIMARY
    } cssc_lim_state_t;

    // Comparator flags from the analog stage
    typedef struct packed {
        logic input_at_active_cap;
        logic input_voltage_at_ref;
        logic input_near_primary_cap;
        logic sys_below_batt_150mv;
        logic charge_current_150ma;
        logic discharge_below_300ma;
        logic battery_below_floor;
        logic battery_above_5v8;
        logic battery_only_mode;
    } cssc_sense_t;

    // Controls to the power stage
    typedef struct packed {
        logic battery_isolation_fet;
        logic input_power_limit;
        logic use_secondary_cap;
        logic input_current_monitor_out;
        logic discharge_monitor_out;
        logic platform_power_monitor;
        logic trickle_charge;
        logic fast_charge;
        logic regulate_at_floor;
        logic regulate_at_ceiling;
    } cssc_drive_t;

endpackage : cssc_pkg

// file: rtl/cssc_tick_timer.sv
`timescale 1ns/1ps
`default_nettype none

module cssc_tick_timer #(
    parameter int unsigned LIMIT = 20
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Control
    input  wire logic tick,
    input  wire logic run,
    input  wire logic restart,
    // Expiry pulse
    output logic      done
);
    logic [31:0] count;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count <= 32'h0000_0000;
        end else if (restart || !run) begin
            count <= 32'h0000_0000;
        end else if (tick && count != 32'(LIMIT)) begin
            count <= count + 32'h0000_0001;
        end
    end

    // Fires once; the count parks at the limit until restarted or run drops
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            done <= 1'b0;
        end else begin
            done <= run && !restart && tick && count == 32'(LIMIT - 1);
        end
    end

endmodule : cssc_tick_timer

`default_nettype wire

// file: rtl/cssc_two_level.sv
`timescale 1ns/1ps
`default_nettype none

module cssc_two_level
    import cssc_pkg::*;
#(
    parameter int unsigned T1_CYCLES = 100000,
    parameter int unsigned T2_CYCLES = 100000
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Control
    input  wire logic enable,
    input  wire logic start,
    // Cap choice
    output logic      use_secondary
);
    cssc_lim_state_t state;
    logic [31:0]     count;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= CSSC_LIM_IDLE;
            count <= 32'h0000_0000;
        end else if (!enable) begin
            state <= CSSC_LIM_IDLE;
            count <= 32'h0000_0000;
        end else begin
            case (state)
                CSSC_LIM_IDLE: begin
                    count <= 32'h0000_0000;
                    if (start) begin
                        state <= CSSC_LIM_SECONDARY;
                    end
                end
                CSSC_LIM_SECONDARY: begin
                    if (count >= 32'(T2_CYCLES - 1)) begin
                        state <= CSSC_LIM_PRIMARY;
                        count <= 32'h0000_0000;
                    end else begin
                        count <= count + 32'h0000_0001;
                    end
                end
                CSSC_LIM_PRIMARY: begin
                    if (count >= 32'(T1_CYCLES - 1)) begin
                        state <= CSSC_LIM_SECONDARY;
                        count <= 32'h0000_0000;
                    end else begin
                        count <= count + 32'h0000_0001;
                    end
                end
                default: begin
                    state <= CSSC_LIM_IDLE;
                    count <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign use_secondary = (state == CSSC_LIM_SECONDARY);

endmodule : cssc_two_level

`default_nettype wire

// file: rtl/cssc_charger_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "cssc_defs.svh"

// What this block does
// - Limit input power at the active cap or when input voltage hits its reference.
// - While limiting, turn the isolation FET on when system sits 150mV under battery.
// - Leave turbo on 150mA charge, or discharge under 300mA beyond 20ms.
// - FET state follows turbo-disable bit and zero or nonzero fill setting.
// - Limiter starts near primary cap: secondary for t2, primary for t1, repeat.
// - Primary cap may be above or below secondary; no ordering enforced.
// - Word C bit 12 enables two-level limiting; otherwise primary cap only.
// - Word B bits 5 and 4 gate input and discharge monitor outputs.
// - Word B bit 3 gates the platform power monitor.
// - On battery alone, platform monitor stays off below 5.8V battery.
// - Nonzero fill setting allows trickle; trickle only while battery under floor.
// - Word C bits 15:14 select the trickle current level.
// - During trickle, FET loop holds system at the floor voltage.
// - At or above floor, charge fast capped at the fast fill cap.
// - No battery or FET off: regulate system at the ceiling.
// - Without ceiling or fill writes for 175s, charging ends with FET off.
// - Watchdog termination leaves the stored fill setting untouched.
// - After termination, charging resumes only on a ceiling or fill write.
// - Word A bit 7 disables the watchdog.
// - Charge only with nonzero fill setting and battery present.
module cssc_charger_supervisor
    import cssc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `CSSC_TICK_CYCLES,
    parameter int unsigned TURBO_TICKS = `CSSC_TURBO_EXIT_MS,
    parameter int unsigned WD_TICKS    = `CSSC_WD_TICKS,
    parameter int unsigned T1_CYCLES   = `CSSC_T1_CYCLES,
    parameter int unsigned T2_CYCLES   = `CSSC_T2_CYCLES
) (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               reset,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Analog status
    input  wire cssc_pkg::cssc_sense_t sense,
    input  wire logic               battery_absent_input,
    // Power stage controls
    output cssc_pkg::cssc_drive_t   drive,
    output logic      [15:0]        active_input_cap,
    output logic      [15:0]        fast_fill_limit,
    output logic      [1:0]         input_voltage_ref,
    output logic      [1:0]         trickle_level,
    output logic                    charging_terminated
);
    import cssc_pkg::*;

    logic [15:0] configuration_word_a;
    logic [15:0] configuration_word_b;
    logic [15:0] configuration_word_c;
    logic [15:0] input_current_cap_primary;
    logic [15:0] input_current_cap_secondary;
    logic [15:0] battery_fill_setting;
    logic [15:0] fast_fill_cap;
    logic [15:0] system_voltage_ceiling;
    logic [15:0] system_voltage_floor;

    logic        access;
    logic        wr_en;
    logic        wd_write;
    logic        mapped;
    logic [15:0] status_word;
    logic [31:0] next_prdata;

    logic [31:0] prescale;
    logic        tick;
    logic        turbo;
    logic        turbo_exit_done;
    logic        wd_done;
    logic        lim_secondary;

    logic        two_level_en;
    logic        fill_nonzero;
    logic        turbo_disabled;
    logic        charge_allowed;
    logic        limiting;
    logic        next_turbo;
    logic        next_fet;
    cssc_drive_t next_drive;

    // APB decode; writes land on the access edge
    assign access   = psel && penable && pready;
    assign wr_en    = access && pwrite;
    assign wd_write = wr_en && (paddr == `CSSC_ADDR_CEILING || paddr == `CSSC_ADDR_FILL);

    always_comb begin
        case (paddr)
            `CSSC_ADDR_WORD_A, `CSSC_ADDR_WORD_B, `CSSC_ADDR_WORD_C,
            `CSSC_ADDR_CAP_PRI, `CSSC_ADDR_CAP_SEC, `CSSC_ADDR_FILL,
            `CSSC_ADDR_FAST_CAP, `CSSC_ADDR_CEILING, `CSSC_ADDR_FLOOR,
            `CSSC_ADDR_STATUS: mapped = 1'b1;
            default:           mapped = 1'b0;
        endcase
    end

    // Zero wait states: ready is raised for the access phase only
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end

    assign status_word = {8'h00, drive.platform_power_monitor, charging_terminated,
                          drive.fast_charge, drive.trickle_charge, lim_secondary,
                          drive.input_power_limit, turbo, drive.battery_isolation_fet};

    always_comb begin
        case (paddr)
            `CSSC_ADDR_WORD_A:   next_prdata = {16'h0000, configuration_word_a};
            `CSSC_ADDR_WORD_B:   next_prdata = {16'h0000, configuration_word_b};
            `CSSC_ADDR_WORD_C:   next_prdata = {16'h0000, configuration_word_c};
            `CSSC_ADDR_CAP_PRI:  next_prdata = {16'h0000, input_current_cap_primary};
            `CSSC_ADDR_CAP_SEC:  next_prdata = {16'h0000, input_current_cap_secondary};
            `CSSC_ADDR_FILL:     next_prdata = {16'h0000, battery_fill_setting};
            `CSSC_ADDR_FAST_CAP: next_prdata = {16'h0000, fast_fill_cap};
            `CSSC_ADDR_CEILING:  next_prdata = {16'h0000, system_voltage_ceiling};
            `CSSC_ADDR_FLOOR:    next_prdata = {16'h0000, system_voltage_floor};
            `CSSC_ADDR_STATUS:   next_prdata = {16'h0000, status_word};
            default:             next_prdata = 32'h0000_0000;
        endcase
    end

    // Captured in setup so the data is steady through access
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // Register file; caps stored as written, in any order
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            configuration_word_a        <= `CSSC_RST_WORD_A;
            configuration_word_b        <= `CSSC_RST_WORD_B;
            configuration_word_c        <= `CSSC_RST_WORD_C;
            input_current_cap_primary   <= `CSSC_RST_CAP_PRI;
            input_current_cap_secondary <= `CSSC_RST_CAP_SEC;
            battery_fill_setting        <= `CSSC_RST_FILL;
            fast_fill_cap               <= `CSSC_RST_FAST_CAP;
            system_voltage_ceiling      <= `CSSC_RST_CEILING;
            system_voltage_floor        <= `CSSC_RST_FLOOR;
        end else if (wr_en) begin
            case (paddr)
                `CSSC_ADDR_WORD_A:   configuration_word_a        <= pwdata[15:0];
                `CSSC_ADDR_WORD_B:   configuration_word_b        <= pwdata[15:0];
                `CSSC_ADDR_WORD_C:   configuration_word_c        <= pwdata[15:0];
                `CSSC_ADDR_CAP_PRI:  input_current_cap_primary   <= pwdata[15:0];
                `CSSC_ADDR_CAP_SEC:  input_current_cap_secondary <= pwdata[15:0];
                `CSSC_ADDR_FILL:     battery_fill_setting        <= pwdata[15:0];
                `CSSC_ADDR_FAST_CAP: fast_fill_cap               <= pwdata[15:0];
                `CSSC_ADDR_CEILING:  system_voltage_ceiling      <= pwdata[15:0];
                `CSSC_ADDR_FLOOR:    system_voltage_floor        <= pwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // Millisecond prescaler shared by both slow timers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            prescale <= 32'h0000_0000;
            tick     <= 1'b0;
        end else if (prescale >= 32'(TICK_CYCLES - 1)) begin
            prescale <= 32'h0000_0000;
            tick     <= 1'b1;
        end else begin
            prescale <= prescale + 32'h0000_0001;
            tick     <= 1'b0;
        end
    end

    // Low discharge must hold unbroken; any break restarts the count
    cssc_tick_timer #(
        .LIMIT (TURBO_TICKS)
    ) u_turbo_exit (
        .clock   (clock),
        .reset   (reset),
        .tick    (tick),
        .run     (turbo && sense.discharge_below_300ma),
        .restart (1'b0),
        .done    (turbo_exit_done)
    );

    // Watchdog count is held at zero while disabled or already terminated
    cssc_tick_timer #(
        .LIMIT (WD_TICKS)
    ) u_watchdog (
        .clock   (clock),
        .reset   (reset),
        .tick    (tick),
        .run     (!configuration_word_a[`CSSC_A_WD_DIS] && !charging_terminated),
        .restart (wd_write),
        .done    (wd_done)
    );

    // Expiry wins over a write in the same cycle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            charging_terminated <= 1'b0;
        end else if (wd_done) begin
            charging_terminated <= 1'b1;
        end else if (wd_write) begin
            charging_terminated <= 1'b0;
        end
    end

    assign two_level_en = configuration_word_c[`CSSC_C_TWO_LEVEL];

    cssc_two_level #(
        .T1_CYCLES (T1_CYCLES),
        .T2_CYCLES (T2_CYCLES)
    ) u_two_level (
        .clock         (clock),
        .reset         (reset),
        .enable        (two_level_en),
        .start         (sense.input_near_primary_cap),
        .use_secondary (lim_secondary)
    );

    // Secondary cap only matters while the pattern is running
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            active_input_cap <= `CSSC_RST_CAP_PRI;
        end else if (two_level_en && lim_secondary) begin
            active_input_cap <= input_current_cap_secondary;
        end else begin
            active_input_cap <= input_current_cap_primary;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            input_voltage_ref <= 2'h0;
            trickle_level     <= 2'h0;
            fast_fill_limit   <= `CSSC_RST_FAST_CAP;
        end else begin
            input_voltage_ref <= configuration_word_a[`CSSC_A_VREF_HI:`CSSC_A_VREF_LO];
            trickle_level     <= configuration_word_c[`CSSC_C_TRICKLE_HI:`CSSC_C_TRICKLE_LO];
            fast_fill_limit   <= fast_fill_cap;
        end
    end

    assign fill_nonzero   = (battery_fill_setting != 16'h0000);
    assign turbo_disabled = configuration_word_a[`CSSC_A_TURBO_DIS];
    assign limiting       = sense.input_at_active_cap || sense.input_voltage_at_ref;
    assign charge_allowed = fill_nonzero && !battery_absent_input && !charging_terminated;

    // Turbo entry and exit
    always_comb begin
        next_turbo = turbo;
        if (turbo && (sense.charge_current_150ma || turbo_exit_done)) begin
            next_turbo = 1'b0;
        end else if (!turbo && limiting && sense.sys_below_batt_150mv) begin
            next_turbo = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            turbo <= 1'b0;
        end else begin
            turbo <= next_turbo;
        end
    end

    // FET truth table; termination overrides it
    always_comb begin
        if (charging_terminated) begin
            next_fet = 1'b0;
        end else if (next_turbo) begin
            next_fet = !turbo_disabled || fill_nonzero;
        end else begin
            next_fet = fill_nonzero;
        end
    end

    always_comb begin
        next_drive.battery_isolation_fet     = next_fet;
        next_drive.input_power_limit         = limiting;
        next_drive.use_secondary_cap         = two_level_en && lim_secondary;
        next_drive.input_current_monitor_out = configuration_word_b[`CSSC_B_INPUT_CURRENT_MONITOR_OUT_EN];
        next_drive.discharge_monitor_out     = configuration_word_b[`CSSC_B_DISCHARGE_MONITOR_OUT_EN];
        next_drive.platform_power_monitor    = configuration_word_b[`CSSC_B_PLATFORM_POWER_MONITOR_EN]
            && !(sense.battery_only_mode && !sense.battery_above_5v8);
        next_drive.trickle_charge            = charge_allowed && sense.battery_below_floor;
        next_drive.fast_charge               = charge_allowed && !sense.battery_below_floor;
        next_drive.regulate_at_floor         = charge_allowed && sense.battery_below_floor;
        next_drive.regulate_at_ceiling       = battery_absent_input || !next_fet;
    end

    // Registered so every control leaves a flip-flop
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            drive <= '0;
        end else begin
            drive <= next_drive;
        end
    end

endmodule : cssc_charger_supervisor

`default_nettype wire

// file: testbench/cssc_charger_supervisor_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module cssc_charger_supervisor_monitor
    import cssc_pkg::*;
(
    // Clock and reset
    input wire logic                  clock,
    input wire logic                  reset,
    // Bus handshake
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Power stage
    input wire cssc_pkg::cssc_sense_t sense,
    input wire logic                  battery_absent_input,
    input wire cssc_pkg::cssc_drive_t drive,
    input wire logic                  charging_terminated
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    bus_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    bus_access_a: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("answer outside access");
    err_qual_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    limit_entry_a: assert property (
        sense.input_at_active_cap || sense.input_voltage_at_ref |=> drive.input_power_limit)
        else $error("no input limiting");
    trickle_floor_a: assert property (
        drive.trickle_charge |-> $past(sense.battery_below_floor) && drive.regulate_at_floor)
        else $error("bad trickle");
    fast_floor_a: assert property (
        drive.fast_charge |-> !$past(sense.battery_below_floor) && !drive.trickle_charge)
        else $error("bad fast charge");
    absent_idle_a: assert property (
        battery_absent_input [*2] |-> !drive.trickle_charge && !drive.fast_charge
            && drive.regulate_at_ceiling)
        else $error("charging without battery");
    platform_power_monitor_low_a: assert property (
        (sense.battery_only_mode && !sense.battery_above_5v8) [*2]
            |-> !drive.platform_power_monitor)
        else $error("platform monitor on low battery");
    term_off_a: assert property (
        charging_terminated [*2] |-> !drive.battery_isolation_fet && !drive.fast_charge
            && !drive.trickle_charge)
        else $error("charging after termination");

    // Main scenarios reached
    trickle_c: cover property (drive.trickle_charge);
    two_level_c: cover property (drive.use_secondary_cap);
    turbo_c: cover property (drive.battery_isolation_fet && drive.input_power_limit);
    term_c: cover property (charging_terminated);
endmodule : cssc_charger_supervisor_monitor

`default_nettype wire

// file: testbench/cssc_stage_model.sv
`timescale 1ns/1ps
`default_nettype none

module cssc_stage_model
    import cssc_pkg::*;
(
    // Clock and reset
    input wire logic                  clock,
    input wire logic                  reset,
    // Requested levels
    input wire cssc_pkg::cssc_sense_t want,
    input wire logic                  want_absent,
    // Comparator outputs
    output var cssc_pkg::cssc_sense_t sense,
    output var logic                  battery_absent_input
);
    // Comparators settle one edge late, as the real stage does
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sense <= '0;
            battery_absent_input <= 1'h0;
        end else begin
            sense <= want;
            battery_absent_input <= want_absent;
        end
    end
endmodule : cssc_stage_model

`default_nettype wire

// file: testbench/cssc_charger_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end

module cssc_charger_supervisor_tb;
    import cssc_pkg::*;
    logic        clock, reset, psel, penable, pwrite, pready, pslverr, err;
    logic        absent, bat_absent, charging_terminated;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r, v;
    logic [15:0] active_input_cap, fast_fill_limit, pc, sc;
    logic [1:0]  input_voltage_ref, trickle_level;
    cssc_sense_t want, sense;
    cssc_drive_t drv;
    int          num_errors, n_compared, n, i;
    integer      seed;

    cssc_charger_supervisor #(.TICK_CYCLES(10), .TURBO_TICKS(20), .WD_TICKS(5),
        .T1_CYCLES(8), .T2_CYCLES(8)) i_dut (.clock(clock), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sense(sense), .battery_absent_input(bat_absent), .drive(drv),
        .active_input_cap(active_input_cap), .fast_fill_limit(fast_fill_limit),
        .input_voltage_ref(input_voltage_ref), .trickle_level(trickle_level),
        .charging_terminated(charging_terminated));
    cssc_stage_model i_stage (.clock(clock), .reset(reset), .want(want),
        .want_absent(absent), .sense(sense), .battery_absent_input(bat_absent));

    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    task automatic summarize;
        if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize

    // Holds the request until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do @(posedge clock); while (pready !== 1'h1);
        r = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic settle;
        repeat (4) @(posedge clock);
    endtask : settle

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        summarize();
    end

    initial begin
        seed = 32'hc3455a3d;
        {psel, penable, pwrite, paddr, pwdata, want, absent} = '0;
        reset = 1'h1;
        repeat (6) @(posedge clock);
        reset <= 1'h0;
        // Watchdog off first, it is short here
        apb(1'h1, 8'h00, 32'h80);
        for (i = 1; i < 10; i++) begin
            apb(1'h0, 8'(i * 4), 32'h0);
            `CHK(r, 32'h0)
        end
        apb(1'h0, 8'h28, 32'h0);
        `CHK(err, 1'h1)
        repeat (6) begin
            v = $random(seed);
            apb(1'h1, 8'h04, v);
            apb(1'h1, 8'h08, v & 32'hc000);
            apb(1'h1, 8'h00, (v >> 16) & 32'h3 | 32'h80);
            want <= cssc_sense_t'({7'h0, v[21:20]});
            settle();
            `CHK(drv.input_current_monitor_out, v[5])
            `CHK(drv.discharge_monitor_out, v[4])
            `CHK(drv.platform_power_monitor, v[3] & ~(v[20] & ~v[21]))
            `CHK(input_voltage_ref, v[17:16])
            `CHK(trickle_level, v[15:14])
            apb(1'h0, 8'h04, 32'h0);
            `CHK(r, {16'h0, v[15:0]})
        end
        for (i = 0; i < 8; i++) begin
            v = $random(seed) | 32'h1;
            apb(1'h1, 8'h18, v);
            apb(1'h1, 8'h14, i[0] ? v : 32'h0);
            want <= cssc_sense_t'({6'h0, i[1], 2'h0});
            absent <= i[2];
            settle();
            `CHK(drv.trickle_charge, i[0] & i[1] & ~i[2])
            `CHK(drv.regulate_at_floor, i[0] & i[1] & ~i[2])
            `CHK(drv.fast_charge, i[0] & ~i[1] & ~i[2])
            `CHK(fast_fill_limit, v[15:0])
            if (i[2]) `CHK(drv.regulate_at_ceiling, 1'h1)
            else `CHK(drv.battery_isolation_fet, i[0])
        end
        absent <= 1'h0;
        apb(1'h1, 8'h14, 32'h0);
        for (i = 1; i >= 0; i--) begin
            apb(1'h1, 8'h00, 32'h80 | i << 2);
            want <= 9'h120;
            settle();
            `CHK(drv.input_power_limit, 1'h1)
            `CHK(drv.battery_isolation_fet, ~i[0])
        end
        want <= 9'h000;
        settle();
        `CHK(drv.battery_isolation_fet, 1'h1)
        want <= 9'h010;
        settle();
        `CHK(drv.battery_isolation_fet, 1'h0)
        want <= 9'h120;
        settle();
        want <= 9'h008;
        repeat (150) @(posedge clock);
        `CHK(drv.battery_isolation_fet, 1'h1)
        repeat (80) @(posedge clock);
        `CHK(drv.battery_isolation_fet, 1'h0)
        for (i = 0; i < 2; i++) begin
            v = $random(seed);
            pc = {i[0], v[14:0]};
            sc = {~i[0], v[14:0]};
            apb(1'h1, 8'h0c, {16'h0, pc});
            apb(1'h1, 8'h10, {16'h0, sc});
            apb(1'h1, 8'h08, 32'h1000);
            want <= 9'h040;
            for (n = 0; drv.use_secondary_cap !== 1'h1 && n < 50; n++) @(posedge clock);
            @(posedge clock);
            `CHK(active_input_cap, sc)
            for (n = 1; drv.use_secondary_cap === 1'h1 && n < 40; n++) @(posedge clock);
            `CHK(n, 8)
            for (n = 0; drv.use_secondary_cap === 1'h0 && n < 40; n++) @(posedge clock);
            `CHK(n, 8)
            apb(1'h1, 8'h08, 32'h0);
            settle();
            `CHK(drv.use_secondary_cap, 1'h0)
            `CHK(active_input_cap, pc)
        end
        want <= 9'h000;
        apb(1'h1, 8'h14, 32'h5a5a);
        repeat (100) @(posedge clock);
        `CHK(charging_terminated, 1'h0)
        apb(1'h1, 8'h00, 32'h0);
        for (n = 0; charging_terminated !== 1'h1 && n < 200; n++) @(posedge clock);
        settle();
        `CHK(drv.fast_charge, 1'h0)
        `CHK(drv.battery_isolation_fet, 1'h0)
        apb(1'h0, 8'h14, 32'h0);
        `CHK(r, 32'h5a5a)
        `CHK(charging_terminated, 1'h1)
        apb(1'h1, 8'h1c, 32'h1234);
        settle();
        `CHK(charging_terminated, 1'h0)
        `CHK(drv.fast_charge, 1'h1)
        summarize();
    end
endmodule : cssc_charger_supervisor_tb

bind cssc_charger_supervisor cssc_charger_supervisor_monitor i_mon (.clock(clock),
    .reset(reset), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .sense(sense), .battery_absent_input(battery_absent_input), .drive(drive),
    .charging_terminated(charging_terminated));

`default_nettype wire
